//--- logic/force_limit_pkg.sv
/*
  Shared constants and types for the force limit supervisor.
  Assumes values are signed fixed point in thousandths of a unit.
*/
package force_limit_pkg;
  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int VAL_W = 32;
  localparam int CLK_HZ = 25_000_000;
  localparam int MINUTE_S = 60;
  localparam int CYC_PER_MIN = CLK_HZ * MINUTE_S;
  // ----------------------------------------------------------------
  // step sizes (index into decades, thousandths)
  // ----------------------------------------------------------------
  localparam logic [2:0] STEP_MIN_IDX = 3'h0;
  localparam logic [2:0] STEP_MAX_IDX = 3'h5;
  localparam logic [2:0] STEP_RESET = 3'h3;
  // ----------------------------------------------------------------
  // value limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [31:0] VAL_MAX = 32'h3FFFFFFF;
  localparam logic signed [31:0] VAL_MIN = 32'hC0000001;
  localparam logic signed [31:0] VAL_ZERO = 32'h00000000;
  localparam logic signed [31:0] BW_MAX = 32'h0000C350;
  localparam logic signed [63:0] BW_FULL = 64'h00000000000186A0;
  localparam logic signed [31:0] RNG_HI_RESET = 32'h00002EE0;
  localparam logic signed [31:0] RNG_LO_RESET = 32'h00002710;
  localparam logic signed [31:0] NOM_RESET = 32'h00002710;
  localparam logic signed [31:0] BW_RESET = 32'h00002710;
  localparam logic signed [31:0] LOAD_HI_RESET = 32'h000186A0;
  localparam logic signed [31:0] LOAD_LO_RESET = 32'hFFFE7960;
  localparam logic [8:0] SD_MIN = 9'h00A;
  localparam logic [8:0] SD_MAX = 9'h1E0;
  localparam logic [8:0] SD_STEP = 9'h00A;
  localparam logic [8:0] SD_RESET = 9'h03C;
  // ----------------------------------------------------------------
  // alarm characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_HIGH = 8'h24;
  localparam logic [7:0] CHAR_LOW = 8'h22;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PAGE_NONE = 4'h0,
    PAGE_PF_ENABLE = 4'h1,
    PAGE_PF_METHOD = 4'h2,
    PAGE_RANGE = 4'h3,
    PAGE_NOMINAL = 4'h4,
    PAGE_LOAD = 4'h5,
    PAGE_XMIT = 4'h6,
    PAGE_BUZZER = 4'h7,
    PAGE_SHUTDOWN = 4'h8
  } setup_page_type;
  typedef enum logic {METH_RANGE = 1'b0, METH_NOMINAL = 1'b1} method_type;
  typedef enum logic {FIELD_A = 1'b0, FIELD_B = 1'b1} field_type;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_type;
endpackage

//--- logic/limit_alarm_if.sv
/*
  Carrier between the supervisor and its alarm character sender.
  Assumes both ends run on clk_sys.
*/
interface limit_alarm_if;
  logic send_en; // transmission allowed
  logic high_hit; // compression limit reached
  logic low_hit; // tension limit reached
  logic tx_ready; // serializer accepts a character
  logic [7:0] tx_data; // character offered
  logic tx_valid; // character offered this cycle
  modport ctrl (output send_en, high_hit, low_hit, tx_ready,
    input tx_data, tx_valid);
  modport sender (input send_en, high_hit, low_hit, tx_ready,
    output tx_data, tx_valid);
endinterface

//--- logic/alarm_char_sender.sv
/*
  Offers alarm characters back to back while a limit stays reached.
  Assumes a serializer that takes a character on valid and ready.
*/
module alarm_char_sender
  import force_limit_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic clk_en, // freezes state when low
  limit_alarm_if.sender lnk // alarm link
);
  tx_state_type state_reg;
  logic [7:0] data_reg;
  logic take;
  logic want;
  assign take = (state_reg == TX_SEND) && lnk.tx_ready;
  assign want = lnk.send_en && (lnk.high_hit || lnk.low_hit);
  assign lnk.tx_data = data_reg;
  assign lnk.tx_valid = (state_reg == TX_SEND);

  // offer a new character when idle or after one was taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= TX_IDLE;
      data_reg <= 8'h00;
    end else if (clk_en) begin
      case (state_reg)
        TX_IDLE: begin
          if (want) begin
            state_reg <= TX_SEND;
            data_reg <= lnk.high_hit ? CHAR_HIGH : CHAR_LOW;
          end
        end
        TX_SEND: begin
          if (take) begin
            state_reg <= want ? TX_SEND : TX_IDLE;
            data_reg <= lnk.high_hit ? CHAR_HIGH : CHAR_LOW;
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule // alarm_char_sender

//--- logic/idle_shutdown_timer.sv
/*
  Inactivity timer that requests power down after a set interval.
  Assumes activity is a one-cycle pulse on clk_sys.
*/
module idle_shutdown_timer
  import force_limit_pkg::*;
#(
  parameter int CYCLES_PER_MIN = CYC_PER_MIN
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic clk_en, // freezes state when low
  input wire logic enable, // auto shutdown on
  input wire logic activity, // key or link event
  input wire logic [8:0] interval, // minutes
  output logic shutdown // power down request
);
  logic [31:0] pre_reg;
  logic [8:0] min_reg;
  logic tick;
  assign tick = (pre_reg == 32'(CYCLES_PER_MIN - 1));

  // minute prescaler and minute count, restarted by activity
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_reg <= 32'h00000000;
      min_reg <= 9'h000;
    end else if (clk_en) begin
      if (!enable || activity) begin
        pre_reg <= 32'h00000000;
        min_reg <= 9'h000;
      end else if (tick) begin
        pre_reg <= 32'h00000000;
        if (min_reg != 9'h1FF) min_reg <= min_reg + 9'h001;
      end else begin
        pre_reg <= pre_reg + 32'h00000001;
      end
    end
  end

  // request held until reset once the interval is used up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) shutdown <= 1'b0;
    else if (clk_en && enable && min_reg >= interval) shutdown <= 1'b1;
  end
endmodule // idle_shutdown_timer

//--- logic/force_limit_check_shutdown.sv
/*
  Pass/fail evaluation, load limit tags, alarm characters and
  inactivity shutdown for a handheld force gauge.
  Assumes key and sample strobes are one-cycle pulses on clk_sys.
*/
// Operation
// - pass/fail starts off after reset; setup select key toggles it.
// - two methods only: range limits, or nominal plus bandwidth.
// - range method passes when low <= result <= high, else fails.
// - nominal method derives limits and fails outside them.
// - derived limits follow nominal and bandwidth changes automatically.
// - bandwidth is percent of nominal and never above fifty.
// - entering nominal setup with pass/fail on selects nominal first.
// - six step decades; right key larger, left key smaller.
// - up or down adds or subtracts the selected step, clamped to the limits.
// - high load limit is kept at zero or above.
// - low load limit is kept at zero or below.
// - tension and compression tags stay while the limit is reached.
// - load limits are checked whatever the measurement mode.
// - low-alarm tag set below low setpoint, cleared above it.
// - buzzer on sounds and flags when a limit is exceeded; icon shown.
// - limit transmission off at reset; right on, left off.
// - high limit reached sends dollar signs repeatedly while it lasts.
// - low limit reached sends double quotes repeatedly; tester stops.
// - power down after idle interval; feature off at reset.
// - idle interval kept within ten to four hundred eighty minutes.
// - up or down moves the idle interval by ten minutes.
// - third-party gauge output disables the alarm characters.
module force_limit_check_shutdown
  import force_limit_pkg::*;
#(
  parameter int CYCLES_PER_MIN = CYC_PER_MIN
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic clk_en, // freezes all state when low
  input wire setup_page_type page, // active setup screen
  input wire logic key_up, // up key pulse
  input wire logic key_down, // down key pulse
  input wire logic key_left, // left key pulse
  input wire logic key_right, // right key pulse
  input wire logic key_select, // select key pulse
  input wire logic comm_event, // link activity pulse
  input wire logic gauge_out_on, // third-party output enabled
  input wire logic sample_valid, // new measurement pulse
  input wire logic signed [31:0] sample, // measurement, thousandths
  input wire logic tx_ready, // serializer ready
  output logic [7:0] tx_data, // alarm character
  output logic tx_valid, // alarm character valid
  output logic pf_enabled, // pass/fail feature on
  output method_type method, // pass/fail method
  output logic pass_flag, // last result passed
  output logic fail_flag, // last result failed
  output logic signed [31:0] derived_hi, // nominal high limit
  output logic signed [31:0] derived_lo, // nominal low limit
  output field_type edit_field, // B: bandwidth or low
  output logic [2:0] step_index, // step decade
  output logic tension_tag, // low load limit reached
  output logic compression_tag, // high load limit reached
  output logic below_low_setpoint_tag, // below low setpoint
  output logic buzzer_icon, // buzzer option on
  output logic buzzer_sound, // audible alarm
  output logic limit_visual, // visual alarm
  output logic xmit_limits_on, // limit transmission on
  output logic shutdown_icon, // auto shutdown on
  output logic shutdown_req // power down request
);
  // ----------------------------------------------------------------
  // setup registers
  // ----------------------------------------------------------------
  logic signed [31:0] rng_hi_reg, rng_lo_reg;
  logic signed [31:0] nom_reg, bw_reg;
  logic signed [31:0] load_hi_reg, load_lo_reg;
  logic [8:0] sd_min_reg;
  setup_page_type page_reg;
  logic sd_en_reg;
  logic buz_reg;

  // ----------------------------------------------------------------
  // adjustment datapath
  // ----------------------------------------------------------------
  logic signed [31:0] step_val;
  logic signed [31:0] cur_val, min_val, max_val;
  logic signed [32:0] sum_val;
  logic signed [31:0] adj_val;
  logic adj_on;
  logic adj_key;
  logic any_key;

  assign adj_key = key_up || key_down;
  assign any_key = adj_key || key_left || key_right || key_select;

  // step decade to thousandths
  always_comb begin
    case (step_index)
      3'h0: step_val = 32'h00000001;
      3'h1: step_val = 32'h0000000A;
      3'h2: step_val = 32'h00000064;
      3'h3: step_val = 32'h000003E8;
      3'h4: step_val = 32'h00002710;
      3'h5: step_val = 32'h000186A0;
      default: step_val = 32'h000003E8;
    endcase
  end

  // choose the parameter being edited and its bounds
  always_comb begin
    cur_val = VAL_ZERO;
    min_val = VAL_MIN;
    max_val = VAL_MAX;
    adj_on = 1'b0;
    case (page)
      PAGE_RANGE: begin
        adj_on = 1'b1;
        cur_val = (edit_field == FIELD_A) ? rng_hi_reg : rng_lo_reg;
      end
      PAGE_NOMINAL: begin
        adj_on = 1'b1;
        min_val = VAL_ZERO;
        if (edit_field == FIELD_A) begin
          cur_val = nom_reg;
        end else begin
          cur_val = bw_reg;
          max_val = BW_MAX;
        end
      end
      PAGE_LOAD: begin
        adj_on = 1'b1;
        if (edit_field == FIELD_A) begin
          cur_val = load_hi_reg;
          min_val = VAL_ZERO;
        end else begin
          cur_val = load_lo_reg;
          max_val = VAL_ZERO;
        end
      end
      default: adj_on = 1'b0;
    endcase
  end

  // add or subtract one step, then clamp
  always_comb begin
    if (key_up) sum_val = 33'(cur_val) + 33'(step_val);
    else sum_val = 33'(cur_val) - 33'(step_val);
    if (sum_val > 33'(max_val)) adj_val = max_val;
    else if (sum_val < 33'(min_val)) adj_val = min_val;
    else adj_val = sum_val[31:0];
  end

  // ----------------------------------------------------------------
  // feature switches
  // ----------------------------------------------------------------
  // pass/fail enable and method
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pf_enabled <= 1'b0;
      method <= METH_RANGE;
    end else if (clk_en) begin
      if (page == PAGE_PF_ENABLE && key_select)
        pf_enabled <= !pf_enabled;
      if (page == PAGE_PF_METHOD && key_up)
        method <= METH_RANGE;
      if (page == PAGE_PF_METHOD && key_down)
        method <= METH_NOMINAL;
    end
  end

  // transmission, buzzer and shutdown switches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xmit_limits_on <= 1'b0;
      buz_reg <= 1'b0;
      sd_en_reg <= 1'b0;
    end else if (clk_en) begin
      if (page == PAGE_XMIT && key_right) xmit_limits_on <= 1'b1;
      if (page == PAGE_XMIT && key_left) xmit_limits_on <= 1'b0;
      if (page == PAGE_BUZZER && key_select) buz_reg <= !buz_reg;
      if (page == PAGE_SHUTDOWN && key_select) sd_en_reg <= !sd_en_reg;
    end
  end

  // ----------------------------------------------------------------
  // setup navigation
  // ----------------------------------------------------------------
  // step decade: right larger, left smaller
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) step_index <= STEP_RESET;
    else if (clk_en && adj_on) begin
      if (key_right && step_index != STEP_MAX_IDX)
        step_index <= step_index + 3'h1;
      else if (key_left && step_index != STEP_MIN_IDX)
        step_index <= step_index - 3'h1;
    end
  end

  // edited field; nominal page opens on the nominal value when pass/fail is on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      page_reg <= PAGE_NONE;
      edit_field <= FIELD_A;
    end else if (clk_en) begin
      page_reg <= page;
      if (page != page_reg) begin
        if (page == PAGE_NOMINAL && pf_enabled) edit_field <= FIELD_A;
        else if (page != PAGE_NOMINAL) edit_field <= FIELD_A;
      end else if (adj_on && key_select) begin
        edit_field <= (edit_field == FIELD_A) ? FIELD_B : FIELD_A;
      end
    end
  end

  // ----------------------------------------------------------------
  // setup values
  // ----------------------------------------------------------------
  // range and nominal parameters
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rng_hi_reg <= RNG_HI_RESET;
      rng_lo_reg <= RNG_LO_RESET;
      nom_reg <= NOM_RESET;
      bw_reg <= BW_RESET;
    end else if (clk_en && adj_on && adj_key && page == page_reg) begin
      case (page)
        PAGE_RANGE: begin
          if (edit_field == FIELD_A) rng_hi_reg <= adj_val;
          else rng_lo_reg <= adj_val;
        end
        PAGE_NOMINAL: begin
          if (edit_field == FIELD_A) nom_reg <= adj_val;
          else bw_reg <= adj_val;
        end
        default: rng_hi_reg <= rng_hi_reg;
      endcase
    end
  end

  // load limits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      load_hi_reg <= LOAD_HI_RESET;
      load_lo_reg <= LOAD_LO_RESET;
    end else if (clk_en && page == PAGE_LOAD && adj_key) begin
      if (edit_field == FIELD_A) load_hi_reg <= adj_val;
      else load_lo_reg <= adj_val;
    end
  end

  // idle interval in ten minute steps
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) sd_min_reg <= SD_RESET;
    else if (clk_en && page == PAGE_SHUTDOWN) begin
      if (key_up && sd_min_reg <= SD_MAX - SD_STEP)
        sd_min_reg <= sd_min_reg + SD_STEP;
      else if (key_down && sd_min_reg >= SD_MIN + SD_STEP)
        sd_min_reg <= sd_min_reg - SD_STEP;
    end
  end

  // ----------------------------------------------------------------
  // derived limits
  // ----------------------------------------------------------------
  logic signed [63:0] span_prod;
  logic signed [63:0] span_val;

  assign span_prod = 64'(nom_reg) * 64'(bw_reg);
  assign span_val = span_prod / BW_FULL;

  // recomputed continuously from nominal and bandwidth
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      derived_hi <= VAL_ZERO;
      derived_lo <= VAL_ZERO;
    end else if (clk_en) begin
      derived_hi <= nom_reg + span_val[31:0];
      derived_lo <= nom_reg - span_val[31:0];
    end
  end

  // ----------------------------------------------------------------
  // pass/fail evaluation
  // ----------------------------------------------------------------
  logic signed [31:0] pf_hi, pf_lo;
  logic in_span;

  assign pf_hi = (method == METH_NOMINAL) ? derived_hi : rng_hi_reg;
  assign pf_lo = (method == METH_NOMINAL) ? derived_lo : rng_lo_reg;
  assign in_span = (sample >= pf_lo) && (sample <= pf_hi);

  // verdict on each sample while the feature is on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pass_flag <= 1'b0;
      fail_flag <= 1'b0;
    end else if (clk_en) begin
      if (!pf_enabled) begin
        pass_flag <= 1'b0;
        fail_flag <= 1'b0;
      end else if (sample_valid) begin
        pass_flag <= in_span;
        fail_flag <= !in_span;
      end
    end
  end

  // ----------------------------------------------------------------
  // load limit indication, in any measurement mode
  // ----------------------------------------------------------------
  // tags follow each sample; no mode input gates them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tension_tag <= 1'b0;
      compression_tag <= 1'b0;
      below_low_setpoint_tag <= 1'b0;
      buzzer_sound <= 1'b0;
      limit_visual <= 1'b0;
    end else if (clk_en && sample_valid) begin
      tension_tag <= (sample <= load_lo_reg);
      compression_tag <= (sample >= load_hi_reg);
      if (sample < load_lo_reg) below_low_setpoint_tag <= 1'b1;
      else if (sample > load_lo_reg) below_low_setpoint_tag <= 1'b0;
      buzzer_sound <= buz_reg &&
        (sample > load_hi_reg || sample < load_lo_reg);
      limit_visual <= buz_reg &&
        (sample > load_hi_reg || sample < load_lo_reg);
    end
  end

  // icons mirror the option switches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buzzer_icon <= 1'b0;
      shutdown_icon <= 1'b0;
    end else if (clk_en) begin
      buzzer_icon <= buz_reg;
      shutdown_icon <= sd_en_reg;
    end
  end

  // ----------------------------------------------------------------
  // alarm characters
  // ----------------------------------------------------------------
  limit_alarm_if alarm_lnk ();

  assign alarm_lnk.send_en = xmit_limits_on && !gauge_out_on;
  assign alarm_lnk.high_hit = compression_tag;
  assign alarm_lnk.low_hit = tension_tag;
  assign alarm_lnk.tx_ready = tx_ready;
  assign tx_data = alarm_lnk.tx_data;
  assign tx_valid = alarm_lnk.tx_valid;

  alarm_char_sender alarm_tx (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .lnk(alarm_lnk.sender)
  );

  // ----------------------------------------------------------------
  // inactivity shutdown
  // ----------------------------------------------------------------
  idle_shutdown_timer #(
    .CYCLES_PER_MIN(CYCLES_PER_MIN)
  ) idle_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .enable(sd_en_reg),
    .activity(any_key || comm_event),
    .interval(sd_min_reg),
    .shutdown(shutdown_req)
  );
endmodule // force_limit_check_shutdown

//--- verification/force_limit_check_shutdown_monitor.sv
/* checker on the supervisor top ports
   assumes a bind to force_limit_check_shutdown, one clk_sys domain */
module force_limit_check_shutdown_monitor
  import force_limit_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic clk_en, // run
  input wire logic sample_valid, // strobe
  input wire logic signed [31:0] sample, // value
  input wire logic tx_ready, // ready
  input wire logic [7:0] tx_data, // char
  input wire logic tx_valid, // valid
  input wire method_type method, // method
  input wire logic pf_enabled, // pass/fail on
  input wire logic pass_flag, // pass
  input wire logic fail_flag, // fail
  input wire logic signed [31:0] derived_hi, // high
  input wire logic signed [31:0] derived_lo, // low
  input wire logic tension_tag, // tension
  input wire logic compression_tag, // compression
  input wire logic buzzer_sound, // buzzer
  input wire logic shutdown_req // power down
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // nominal verdict against the derived span
  property p_nom_fail;
    sample_valid && clk_en && pf_enabled && method == METH_NOMINAL &&
    $stable(derived_hi) && $stable(derived_lo) |=> pass_flag != fail_flag &&
    fail_flag == ($past(sample) > $past(derived_hi) ||
    $past(sample) < $past(derived_lo));
  endproperty
  a_nom_fail: assert property (p_nom_fail) else $error("bad verdict");
  // compression tag never from a negative sample
  property p_hi_sign;
    sample_valid && clk_en && sample < 0 |=> !compression_tag;
  endproperty
  a_hi_sign: assert property (p_hi_sign) else $error("high tag");
  // tags move only on a sample
  property p_tag_hold;
    !(sample_valid && clk_en) |=> $stable(compression_tag) &&
    $stable(tension_tag);
  endproperty
  a_tag_hold: assert property (p_tag_hold) else $error("tag moved");
  // sound only while a load tag stands
  property p_buzz; buzzer_sound |-> compression_tag || tension_tag; endproperty
  a_buzz: assert property (p_buzz) else $error("stray buzzer");
  // offered char held while stalled
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("char dropped");
  // first char follows the tag, compression first
  property p_tx_high;
    $rose(tx_valid) && $past(compression_tag) |-> tx_data == CHAR_HIGH;
  endproperty
  a_tx_high: assert property (p_tx_high) else $error("not high");
  property p_tx_low; $rose(tx_valid) && $past(tension_tag) &&
    !$past(compression_tag) |-> tx_data == CHAR_LOW;
  endproperty
  a_tx_low: assert property (p_tx_low) else $error("not low");
  // power down request latches
  property p_sd_hold; shutdown_req |=> shutdown_req; endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("req fell");
  c_low: cover property (tx_valid && tx_ready && tx_data == CHAR_LOW);
  c_fail: cover property (fail_flag && method == METH_NOMINAL);
  c_sd: cover property ($rose(shutdown_req));
endmodule // force_limit_check_shutdown_monitor
bind force_limit_check_shutdown force_limit_check_shutdown_monitor mon (
  .clk_sys, .rst, .clk_en, .sample_valid, .sample, .tx_ready, .tx_data,
  .tx_valid, .method, .pf_enabled, .pass_flag, .fail_flag, .derived_hi,
  .derived_lo, .tension_tag, .compression_tag, .buzzer_sound, .shutdown_req
);

//--- verification/alarm_tester_model.sv
/* motorised tester taking alarm chars from the serializer side
   assumes a char moves on valid and ready at a clk_sys edge */
module alarm_tester_model
  import force_limit_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic slow, // ready every other cycle
  input wire logic tx_valid, // char offered
  input wire logic [7:0] tx_data, // char
  output logic tx_ready, // accepting
  output int n_hi, // high chars seen
  output int n_lo, // low chars seen
  output logic halt // crosshead stopped
);
  timeunit 1ns / 1ns;
  // take chars, count each alarm and stop the crosshead
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      n_hi <= 0;
      n_lo <= 0;
      halt <= 1'b0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        n_hi <= n_hi + int'(tx_data == CHAR_HIGH);
        n_lo <= n_lo + int'(tx_data == CHAR_LOW);
        halt <= 1'b1;
      end
    end
  end
endmodule // alarm_tester_model

//--- verification/force_limit_check_shutdown_bench.sv
/* bench for the supervisor: key, sample and alarm scenarios
   assumes the tester model and the bound checker */
module force_limit_check_shutdown_bench
  import force_limit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, comm_event = 1'b0, slow = 1'b0;
  logic gauge_out_on = 1'b0, sample_valid = 1'b0;
  logic [4:0] keys = 5'h00; // up down left right select
  setup_page_type page = PAGE_NONE;
  logic signed [31:0] sample = 32'h00000000, derived_hi, derived_lo;
  logic tx_ready, tx_valid, pf_enabled, pass_flag, fail_flag, halt;
  logic tension_tag, compression_tag, below_low_setpoint_tag, buzzer_icon;
  logic buzzer_sound, limit_visual, xmit_limits_on, shutdown_icon;
  logic shutdown_req;
  logic [7:0] tx_data;
  logic [2:0] step_index;
  method_type method;
  field_type edit_field;
  int n_hi, n_lo, cnt, cyc = 0, n_errors = 0, checked = 0;
  logic signed [31:0] rv [4] = '{32'h2EE0, 32'h2EE1, 32'h2710, 32'h270F};
  logic [1:0] rp [4] = '{2'h2, 2'h1, 2'h2, 2'h1};
  force_limit_check_shutdown #(.CYCLES_PER_MIN(10)) DUT (
    .clk_sys, .rst, .clk_en(1'b1), .page, .key_up(keys[0]),
    .key_down(keys[1]), .key_left(keys[2]), .key_right(keys[3]),
    .key_select(keys[4]), .comm_event, .gauge_out_on, .sample_valid,
    .sample, .tx_ready, .tx_data, .tx_valid, .pf_enabled, .method,
    .pass_flag, .fail_flag, .derived_hi, .derived_lo, .edit_field,
    .step_index, .tension_tag, .compression_tag, .below_low_setpoint_tag,
    .buzzer_icon, .buzzer_sound, .limit_visual, .xmit_limits_on,
    .shutdown_icon, .shutdown_req);
  alarm_tester_model tester (.clk_sys, .rst, .slow, .tx_valid, .tx_data,
    .tx_ready, .n_hi, .n_lo, .halt);
  // clock and hang guard
  always #20 clk_sys = !clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      test_done();
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // settle the page, then pulse one key
  task key(input setup_page_type p, input int k);
    page = p;
    @(negedge clk_sys);
    keys[k] = 1'b1;
    @(negedge clk_sys);
    keys = 5'h00;
  endtask
  task smp(input logic signed [31:0] v);
    sample = v;
    sample_valid = 1'b1;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  task test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk({pf_enabled, xmit_limits_on, shutdown_icon}, 3'h0);
    chk({derived_hi, derived_lo}, 64'h00002AF800002328);
    key(PAGE_PF_ENABLE, 4);
    chk(pf_enabled, 1'h1);
    key(PAGE_RANGE, 4);
    for (int i = 0; i < 4; i++) begin
      smp(rv[i]);
      chk({pass_flag, fail_flag}, rp[i]);
    end
    key(PAGE_PF_METHOD, 1);
    chk(method, METH_NOMINAL);
    for (int i = 0; i < 3; i++) key(PAGE_NOMINAL, 3);
    chk({edit_field, step_index}, 4'h5);
    key(PAGE_NOMINAL, 4);
    key(PAGE_NOMINAL, 0);
    @(negedge clk_sys);
    chk({derived_hi, derived_lo}, 64'h00003A9800001388);
    smp(32'h00003A99);
    chk(fail_flag, 1'h1);
    smp(32'h00001388);
    chk(pass_flag, 1'h1);
    for (int i = 0; i < 6; i++) key(PAGE_NOMINAL, 2);
    chk(step_index, 3'h0);
    key(PAGE_BUZZER, 4);
    smp(32'h000186A1);
    chk({buzzer_icon, buzzer_sound, limit_visual}, 3'h7);
    smp(32'h000186A0);
    chk({buzzer_sound, compression_tag, tx_valid}, 3'h2);
    key(PAGE_XMIT, 3);
    slow = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk(n_hi > 4, 1'h1);
    gauge_out_on = 1'b1;
    smp(32'hFFFE795F);
    cnt = n_lo + n_hi;
    repeat (20) @(negedge clk_sys);
    chk(n_lo + n_hi, cnt);
    chk({tension_tag, below_low_setpoint_tag}, 2'h3);
    gauge_out_on = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk({n_lo > 4, halt}, 2'h3);
    key(PAGE_LOAD, 4);
    key(PAGE_LOAD, 0);
    smp(32'hFFFE7961);
    chk({tension_tag, below_low_setpoint_tag}, 2'h3);
    smp(32'h00000000);
    chk({tension_tag, below_low_setpoint_tag}, 2'h0);
    key(PAGE_SHUTDOWN, 4);
    for (int i = 0; i < 6; i++) key(PAGE_SHUTDOWN, 1);
    repeat (90) @(negedge clk_sys);
    chk({shutdown_icon, shutdown_req}, 2'h2);
    comm_event = 1'b1;
    @(negedge clk_sys);
    comm_event = 1'b0;
    repeat (90) @(negedge clk_sys);
    chk(shutdown_req, 1'h0);
    repeat (25) @(negedge clk_sys);
    chk(shutdown_req, 1'h1);
    test_done();
  end
endmodule // force_limit_check_shutdown_bench
